// ==== logic/dhpwm_pkg.sv ====
package dhpwm_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned CNT_W  = 8;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_PERIOD_A = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_PERIOD_B = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_ONTIME_A = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_ONTIME_B = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_MODE     = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_COUNT    = 4'h6;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int unsigned MODE_INDEP_BIT  = 8;
   localparam int unsigned STS_OUT_A_BIT   = 0;
   localparam int unsigned STS_OUT_B_BIT   = 1;
   localparam int unsigned STS_INDEP_BIT   = 2;
   localparam int unsigned STS_PEND_A_BIT  = 3;
   localparam int unsigned STS_PEND_B_BIT  = 4;
   localparam int unsigned STS_BADOFS_BIT  = 5;
   localparam int unsigned CNT_A_LSB       = 0;
   localparam int unsigned CNT_B_LSB       = 8;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [CNT_W-1:0] PERIOD_RST = 8'hFF;
   localparam logic [CNT_W-1:0] ONTIME_RST = 8'h00;
   localparam logic             INDEP_RST  = 1'b0;

   // -----------------------------------------------------------------
   // Timing: one count step lasts this many instruction clocks
   // -----------------------------------------------------------------
   localparam int unsigned STEP_CLKS = 2;

endpackage : dhpwm_pkg

// ==== logic/dhpwm_gen.sv ====
`timescale 1ns/1ps

module dhpwm_gen
   import dhpwm_pkg::*;
#(
   parameter int unsigned WIDTH = dhpwm_pkg::CNT_W
) (
   input  wire logic             clk,          // Instruction clock
   input  wire logic             reset_n,      // Async reset, active low
   input  wire logic             tick,         // One-cycle step enable
   input  wire logic             clear,        // Timer restart after write
   input  wire logic             clear_active, // Output armed after restart
   input  wire logic             start,        // Begin a cycle now
   input  wire logic             wrap_en,      // Own period closes the cycle
   input  wire logic [WIDTH-1:0] period,       // Period in steps minus one
   input  wire logic [WIDTH-1:0] ontime,       // High time in steps
   output logic      [WIDTH-1:0] count,        // Step count within cycle
   output logic                  cyc_begin,    // Pulse: new cycle begins
   output logic                  out           // Registered pwm level
);
   localparam logic [WIDTH-1:0] CNT_ZERO = '0;
   localparam logic [WIDTH-1:0] CNT_MAX  = '1;
   localparam logic [WIDTH-1:0] CNT_ONE  = {{(WIDTH-1){1'b0}}, 1'b1};

   logic [WIDTH-1:0] cnt_q, cnt_d;
   logic [WIDTH-1:0] ont_q, ont_d;
   logic             act_q, act_d;
   logic             out_q, out_d;
   wire              wrap_hit;
   wire              sat_hit;

   assign wrap_hit  = wrap_en && tick && (cnt_q == period);
   assign cyc_begin = !clear && (wrap_hit || start);
   // Counter parks at the top if no cycle start ever arrives
   assign sat_hit   = (cnt_q == CNT_MAX);

   assign cnt_d = clear     ? CNT_ZERO :
                  cyc_begin ? CNT_ZERO :
                  (tick && !sat_hit) ? cnt_q + CNT_ONE : cnt_q;
   assign act_d = clear ? clear_active : (cyc_begin ? 1'b1 : act_q);
   assign ont_d = (clear || cyc_begin) ? ontime : ont_q;
   assign out_d = act_d && (cnt_d < ont_d);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= CNT_ZERO;
         ont_q <= CNT_ZERO;
         act_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         ont_q <= ont_d;
         act_q <= act_d;
         out_q <= out_d;
      end
   end

   assign count = cnt_q;
   assign out   = out_q;

endmodule // dhpwm_gen

// ==== logic/dhpwm_top.sv ====
// Functional notes
// - Two pwm outputs, 8-bit period and ontime
// - Mode bit 8 set: independent generators, restarts shared
// - Step is two clocks; period (value+1)
// - Period and ontime accept 0 through 0xFF
// - High time equals two clocks times ontime
// - Ontime beyond period holds output high
// - Bit 8 clear: shared period from register a
// - Output b rises (offset+1) steps after a
// - Registers writable at any time
// - New ontime effective at next cycle start
// - Period write clears timers, restarts cycles
// - Reset leaves bit 8 clear, offset mode
// - Reset periods 0xFF, ontimes 0x00
`timescale 1ns/1ps

module dhpwm_top
   import dhpwm_pkg::*;
#(
   parameter int unsigned WIDTH = dhpwm_pkg::CNT_W
) (
   input  wire logic                          clk,              // Instruction clock
   input  wire logic                          reset_n,          // Async reset, active low
   input  wire logic [dhpwm_pkg::ADDR_W-1:0]  reg_addr,         // Register address
   input  wire logic [dhpwm_pkg::DATA_W-1:0]  reg_wdata,        // Register write data
   input  wire logic                          reg_wr,           // Write strobe
   input  wire logic                          reg_rd,           // Read strobe
   output logic      [dhpwm_pkg::DATA_W-1:0]  reg_rdata,        // Read data, next cycle
   output logic                               helper_pwm_out_a, // Pwm output a
   output logic                               helper_pwm_out_b  // Pwm output b
);
   import dhpwm_pkg::*;

   // -----------------------------------------------------------------
   // Register state
   // -----------------------------------------------------------------
   logic [WIDTH-1:0]  period_a_q;
   logic [WIDTH-1:0]  period_b_q;
   logic [WIDTH-1:0]  ontime_a_q;
   logic [WIDTH-1:0]  ontime_b_q;
   logic              indep_q;
   logic              pend_a_q;
   logic              pend_b_q;
   logic              restart_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   wire hit_period_a = (reg_addr == OFS_PERIOD_A);
   wire hit_period_b = (reg_addr == OFS_PERIOD_B);
   wire hit_ontime_a = (reg_addr == OFS_ONTIME_A);
   wire hit_ontime_b = (reg_addr == OFS_ONTIME_B);
   wire hit_mode     = (reg_addr == OFS_MODE);
   wire hit_status   = (reg_addr == OFS_STATUS);
   wire hit_count    = (reg_addr == OFS_COUNT);

   wire wr_period_a  = reg_wr && hit_period_a;
   wire wr_period_b  = reg_wr && hit_period_b;
   wire wr_ontime_a  = reg_wr && hit_ontime_a;
   wire wr_ontime_b  = reg_wr && hit_ontime_b;
   wire wr_mode      = reg_wr && hit_mode;

   // Mode changes restart too, so the two outputs never run half-aligned
   wire restart_req  = wr_period_a || wr_period_b || wr_mode;

   // -----------------------------------------------------------------
   // Step divider
   // -----------------------------------------------------------------
   localparam int unsigned DIV_W = $clog2(STEP_CLKS);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_CLKS - 1);
   localparam logic [DIV_W-1:0] DIV_ZERO = '0;
   localparam logic [DIV_W-1:0] DIV_ONE  = DIV_W'(1);

   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_d;
   wire              tick;

   assign tick  = (div_q == DIV_LAST) && !restart_q;
   assign div_d = (restart_q || tick) ? DIV_ZERO : div_q + DIV_ONE;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= DIV_ZERO;
      end else begin
         div_q <= div_d;
      end
   end

   // -----------------------------------------------------------------
   // Register writes
   // -----------------------------------------------------------------
   // writes accepted anytime, full range
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         period_a_q <= PERIOD_RST;
         period_b_q <= PERIOD_RST;
         ontime_a_q <= ONTIME_RST;
         ontime_b_q <= ONTIME_RST;
      end else begin
         if (wr_period_a) begin
            period_a_q <= reg_wdata[WIDTH-1:0];
         end
         if (wr_period_b) begin
            period_b_q <= reg_wdata[WIDTH-1:0];
         end
         if (wr_ontime_a) begin
            ontime_a_q <= reg_wdata[WIDTH-1:0];
         end
         if (wr_ontime_b) begin
            ontime_b_q <= reg_wdata[WIDTH-1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         indep_q <= INDEP_RST;
      end else if (wr_mode) begin
         indep_q <= reg_wdata[MODE_INDEP_BIT];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         restart_q <= 1'b0;
      end else begin
         restart_q <= restart_req;
      end
   end

   // -----------------------------------------------------------------
   // Generators
   // -----------------------------------------------------------------
   logic [WIDTH-1:0] cnt_a;
   logic [WIDTH-1:0] cnt_b;
   logic             begin_a;
   logic             begin_b;
   logic             out_a;
   logic             out_b;
   wire  [WIDTH-1:0] period_b_eff;
   wire              start_b;
   wire              wrap_b_en;
   wire              arm_b;

   assign period_b_eff = indep_q ? period_b_q : period_a_q;
   assign wrap_b_en    = indep_q;
   assign start_b      = !indep_q && tick && (cnt_a == period_b_q);
   // In offset mode b stays low until its first offset point
   assign arm_b        = indep_q;

   dhpwm_gen #(
      .WIDTH        (WIDTH)
   ) u_gen_a (
      .clk          (clk),
      .reset_n      (reset_n),
      .tick         (tick),
      .clear        (restart_q),
      .clear_active (1'b1),
      .start        (1'b0),
      .wrap_en      (1'b1),
      .period       (period_a_q),
      .ontime       (ontime_a_q),
      .count        (cnt_a),
      .cyc_begin    (begin_a),
      .out          (out_a)
   );

   dhpwm_gen #(
      .WIDTH        (WIDTH)
   ) u_gen_b (
      .clk          (clk),
      .reset_n      (reset_n),
      .tick         (tick),
      .clear        (restart_q),
      .clear_active (arm_b),
      .start        (start_b),
      .wrap_en      (wrap_b_en),
      .period       (period_b_eff),
      .ontime       (ontime_b_q),
      .count        (cnt_b),
      .cyc_begin    (begin_b),
      .out          (out_b)
   );

   assign helper_pwm_out_a = out_a;
   assign helper_pwm_out_b = out_b;

   // -----------------------------------------------------------------
   // Pending ontime flags
   // -----------------------------------------------------------------
   // Set by a write, cleared when the value is taken up; a write in the
   // same cycle as the take-up wins, since that value is not yet in use.
   wire take_a = begin_a || restart_q;
   wire take_b = begin_b || restart_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_a_q <= 1'b0;
         pend_b_q <= 1'b0;
      end else begin
         pend_a_q <= wr_ontime_a || (pend_a_q && !take_a);
         pend_b_q <= wr_ontime_b || (pend_b_q && !take_b);
      end
   end

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   // Flags an offset at or above the shared period
   wire              bad_offset = !indep_q && (period_b_q >= period_a_q);
   wire [DATA_W-1:0] mode_word;
   wire [DATA_W-1:0] status_word;
   wire [DATA_W-1:0] count_word;

   assign mode_word   = DATA_W'({indep_q, {MODE_INDEP_BIT{1'b0}}});
   assign status_word = DATA_W'({bad_offset, pend_b_q, pend_a_q,
                                 indep_q, out_b, out_a});
   assign count_word  = {cnt_b, cnt_a};

   always_comb begin
      rdata_d = '0;
      if (!reg_rd) begin
         rdata_d = '0;
      end else if (hit_period_a) begin
         rdata_d = DATA_W'(period_a_q);
      end else if (hit_period_b) begin
         rdata_d = DATA_W'(period_b_q);
      end else if (hit_ontime_a) begin
         rdata_d = DATA_W'(ontime_a_q);
      end else if (hit_ontime_b) begin
         rdata_d = DATA_W'(ontime_b_q);
      end else if (hit_mode) begin
         rdata_d = mode_word;
      end else if (hit_status) begin
         rdata_d = status_word;
      end else if (hit_count) begin
         rdata_d = count_word;
      end else begin
         rdata_d = '0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

endmodule // dhpwm_top

// ==== bench/dhpwm_props.sv ====
`timescale 1ns/1ps

module dhpwm_props
   import dhpwm_pkg::*;
#(
   parameter int unsigned WIDTH = dhpwm_pkg::CNT_W
) (
   input wire logic                         clk,              // Clock
   input wire logic                         reset_n,          // Async reset
   input wire logic [dhpwm_pkg::ADDR_W-1:0] reg_addr,         // Address
   input wire logic [dhpwm_pkg::DATA_W-1:0] reg_wdata,        // Write data
   input wire logic                         reg_wr,           // Write strobe
   input wire logic                         reg_rd,           // Read strobe
   input wire logic [dhpwm_pkg::DATA_W-1:0] reg_rdata,        // Read data
   input wire logic                         helper_pwm_out_a, // Output a
   input wire logic                         helper_pwm_out_b  // Output b
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------
   // Shadow registers
   // ----------------------------------------
   // Ontime changes may wait a whole 512-clock cycle, so judge levels only after a long quiet
   logic [7:0]  per_a_q;
   logic [7:0]  ont_a_q;
   logic [7:0]  ont_b_q;
   logic        ind_q;
   logic [10:0] quiet_q;
   wire         quiet = quiet_q > 11'h44C;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         per_a_q <= PERIOD_RST;
         ont_a_q <= ONTIME_RST;
         ont_b_q <= ONTIME_RST;
         ind_q   <= INDEP_RST;
         quiet_q <= 11'h000;
      end else begin
         if (reg_wr && reg_addr == OFS_PERIOD_A) per_a_q <= reg_wdata[7:0];
         if (reg_wr && reg_addr == OFS_ONTIME_A) ont_a_q <= reg_wdata[7:0];
         if (reg_wr && reg_addr == OFS_ONTIME_B) ont_b_q <= reg_wdata[7:0];
         if (reg_wr && reg_addr == OFS_MODE) ind_q <= reg_wdata[MODE_INDEP_BIT];
         quiet_q <= reg_wr ? 11'h000 : quiet_q + {10'h000, quiet_q != 11'h7FF};
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   sequence s_restart;
      reg_wr && (reg_addr == OFS_PERIOD_A || reg_addr == OFS_PERIOD_B || reg_addr == OFS_MODE)
         ##1 !reg_wr;
   endsequence
   sequence s_wr_rd;
      reg_wr && reg_addr <= OFS_ONTIME_B ##1 reg_rd && reg_addr == $past(reg_addr);
   endsequence
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_rd_unmapped;
      reg_rd && reg_addr > OFS_COUNT |=> reg_rdata == 16'h0000;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
   property p_rd_mode;
      reg_rd && reg_addr == OFS_MODE |=> (reg_rdata & 16'hFEFF) == 16'h0000;
   endproperty
   a_rd_mode: assert property (p_rd_mode) else $error("mode read bits");
   property p_readback;
      s_wr_rd |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 2)};
   endproperty
   a_readback: assert property (p_readback) else $error("readback mismatch");
   property p_rise_a;
      $rose(helper_pwm_out_a) && !$past(reg_wr) |=> helper_pwm_out_a;
   endproperty
   a_rise_a: assert property (p_rise_a) else $error("high shorter than a step");
   property p_fall_a;
      $fell(helper_pwm_out_a) && !$past(reg_wr) |=> !helper_pwm_out_a;
   endproperty
   a_fall_a: assert property (p_fall_a) else $error("low shorter than a step");
   property p_edge_b;
      $changed(helper_pwm_out_b) && !$past(reg_wr) |=> $stable(helper_pwm_out_b);
   endproperty
   a_edge_b: assert property (p_edge_b) else $error("output b off step grid");
   property p_restart;
      s_restart |=> helper_pwm_out_a == (ont_a_q != 8'h00)
         && helper_pwm_out_b == (ind_q && ont_b_q != 8'h00);
   endproperty
   a_restart: assert property (p_restart) else $error("restart levels wrong");
   property p_full_a;
      quiet && ont_a_q > per_a_q |-> helper_pwm_out_a;
   endproperty
   a_full_a: assert property (p_full_a) else $error("long ontime not held high");
   property p_zero_a;
      quiet && ont_a_q == 8'h00 |-> !helper_pwm_out_a;
   endproperty
   a_zero_a: assert property (p_zero_a) else $error("zero ontime not low");
endmodule // dhpwm_props

bind dhpwm_top dhpwm_props #(.WIDTH(WIDTH)) u_props (
   .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .helper_pwm_out_a(helper_pwm_out_a), .helper_pwm_out_b(helper_pwm_out_b));

// ==== bench/dhpwm_meter.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Load model: measures period and high time
// ----------------------------------------
module dhpwm_meter (
   input  wire logic        clk,     // Clock
   input  wire logic        reset_n, // Async reset
   input  wire logic        pin,     // Pwm level at the load
   output logic      [15:0] per_q,   // Clocks between last two rises
   output logic      [15:0] hi_q     // Clocks of last high pulse
);
   logic [15:0] run_q;
   logic [15:0] hrun_q;
   logic        pin_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_q  <= 1'b0;
         run_q  <= 16'h0000;
         hrun_q <= 16'h0000;
         per_q  <= 16'h0000;
         hi_q   <= 16'h0000;
      end else begin
         pin_q  <= pin;
         run_q  <= (pin && !pin_q) ? 16'h0001 : run_q + 16'h0001;
         hrun_q <= pin ? (pin_q ? hrun_q + 16'h0001 : 16'h0001) : hrun_q;
         if (pin && !pin_q) per_q <= run_q;
         if (!pin && pin_q) hi_q <= hrun_q;
      end
   end
endmodule // dhpwm_meter

// ==== bench/tb_dual_helper_pwm_timers.sv ====
`timescale 1ns/1ps

module tb_dual_helper_pwm_timers;
   import dhpwm_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic        out_a;
   logic        out_b;
   logic [15:0] per_a;
   logic [15:0] hi_a;
   logic [15:0] per_b;
   logic [15:0] hi_b;
   int          error_cnt = 0;
   int          checks = 0;
   always #5 clk = ~clk;
   dhpwm_top uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .helper_pwm_out_a(out_a), .helper_pwm_out_b(out_b));
   dhpwm_meter m_a (.clk(clk), .reset_n(reset_n), .pin(out_a), .per_q(per_a), .hi_q(hi_a));
   dhpwm_meter m_b (.clk(clk), .reset_n(reset_n), .pin(out_b), .per_q(per_b), .hi_q(hi_b));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Strobes stay up until the next task, so none is assigned twice in one step
   task automatic step();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      @(posedge clk);
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic wait_edge(input bit b, input logic lvl);
      int   n;
      logic p;
      n = 0;
      do begin
         p = b ? out_b : out_a;
         step();
         n++;
      end while (!((b ? out_b : out_a) === lvl && p !== lvl) && n < 2000);
      if (n >= 2000) begin
         error_cnt++;
         give_verdict();
      end
   endtask
   task automatic measure(input bit b, input logic [15:0] ep, input logic [15:0] eh);
      wait_edge(b, 1'b1);
      wait_edge(b, 1'b1);
      wait_edge(b, 1'b0);
      step();
      chk(b ? per_b : per_a, ep);
      chk(b ? hi_b : hi_a, eh);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      reset_n <= 1'b0;
      repeat (8) step();
      reset_n <= 1'b1;
      step();
      rd(OFS_PERIOD_A, 16'h00FF);
      rd(OFS_PERIOD_B, 16'h00FF);
      rd(OFS_ONTIME_A, 16'h0000);
      rd(OFS_ONTIME_B, 16'h0000);
      rd(OFS_MODE, 16'h0000);
      rd(OFS_STATUS, 16'h0020);
      wr(4'hF, 16'hFFFF);
      rd(4'hF, 16'h0000);
   endtask
   task automatic t_indep();
      wr(OFS_MODE, 16'hFFFF);
      rd(OFS_MODE, 16'h0100);
      wr(OFS_ONTIME_A, 16'h0001);
      wr(OFS_PERIOD_A, 16'h0002);
      wr(OFS_ONTIME_B, 16'h0003);
      wr(OFS_PERIOD_B, 16'h0004);
      rd(OFS_PERIOD_B, 16'h0004);
      measure(1'b0, 16'h0006, 16'h0002);
      measure(1'b1, 16'h000A, 16'h0006);
      wr(OFS_ONTIME_A, 16'h00FF);
      wr(OFS_PERIOD_A, 16'h00FF);
      measure(1'b0, 16'h0200, 16'h01FE);
   endtask
   task automatic t_update();
      wr(OFS_ONTIME_A, 16'h0002);
      wr(OFS_PERIOD_A, 16'h0009);
      wait_edge(1'b0, 1'b1);
      wr(OFS_ONTIME_A, 16'h0006);
      wait_edge(1'b0, 1'b0);
      step();
      chk(hi_a, 16'h0004);
      wait_edge(1'b0, 1'b0);
      step();
      chk(hi_a, 16'h000C);
   endtask
   task automatic t_full();
      int n;
      n = 0;
      wr(OFS_ONTIME_A, 16'h0005);
      wr(OFS_PERIOD_A, 16'h0003);
      repeat (1200) begin
         step();
         n += (out_a === 1'b1);
      end
      chk(16'(n), 16'h04B0);
      wr(OFS_ONTIME_A, 16'h0000);
      wr(OFS_PERIOD_A, 16'h0003);
      n = 0;
      repeat (1200) begin
         step();
         n += (out_a === 1'b0);
      end
      chk(16'(n), 16'h04B0);
   endtask
   task automatic t_offset();
      int n;
      n = 0;
      wr(OFS_MODE, 16'h0000);
      wr(OFS_ONTIME_A, 16'h0003);
      wr(OFS_ONTIME_B, 16'h0002);
      wr(OFS_PERIOD_A, 16'h0009);
      // offset kept below the shared period
      wr(OFS_PERIOD_B, 16'h0003);
      measure(1'b0, 16'h0014, 16'h0006);
      measure(1'b1, 16'h0014, 16'h0004);
      wait_edge(1'b0, 1'b1);
      while (out_b !== 1'b1 && n < 600) begin
         step();
         n++;
      end
      chk(16'(n), 16'h0008);
   endtask
   initial begin
      t_reset();
      t_indep();
      t_update();
      t_full();
      t_offset();
      t_reset();
      give_verdict();
   end
endmodule // tb_dual_helper_pwm_timers
